// [core/tx_stats_pkg.sv]
/*
 * Constants and carrier types for the transmit statistics counter bank.
 * Assumes a 32-bit APB register bus and a transmit datapath on the same clock.
 */
package tx_stats_pkg;

    // Register indices; byte address is four times the index
    localparam logic [11:0] IDX_BCAST_CTRL_LO = 12'h82e;
    localparam logic [11:0] IDX_BCAST_CTRL_HI = 12'h82f;
    localparam logic [11:0] IDX_UCAST_CTRL_LO = 12'h830;
    localparam logic [11:0] IDX_UCAST_CTRL_HI = 12'h831;
    localparam logic [11:0] IDX_PAUSE_LO      = 12'h832;
    localparam logic [11:0] IDX_PAUSE_HI      = 12'h833;
    localparam logic [11:0] IDX_SHORT_LO      = 12'h834;
    localparam logic [11:0] IDX_SHORT_HI      = 12'h835;
    localparam logic [11:0] IDX_CONFIG        = 12'h845;
    localparam logic [11:0] IDX_STATUS        = 12'h846;
    localparam logic [11:0] IDX_PAYLOAD_LO    = 12'h860;
    localparam logic [11:0] IDX_PAYLOAD_HI    = 12'h861;
    localparam logic [11:0] IDX_FRAME_LO      = 12'h862;
    localparam logic [11:0] IDX_FRAME_HI      = 12'h863;

    // Field positions
    localparam int CFG_RESET_BIT   = 0;
    localparam int CFG_PCLR_BIT    = 1;
    localparam int CFG_FREEZE_BIT  = 2;
    localparam int STS_PERR_BIT    = 0;
    localparam int STS_FROZEN_BIT  = 1;
    localparam int MAC_VLAN_OFF_BIT = 1;

    // Reset values
    localparam logic RST_FREEZE = 1'b0;
    localparam logic RST_PERR   = 1'b0;

    // Frame length limits and VLAN header sizes, in bytes
    localparam logic [15:0] MIN_TX_BYTES    = 16'h0009;
    localparam logic [15:0] PAD_TX_BYTES    = 16'h0040;
    localparam logic [15:0] VLAN_ONE_BYTES  = 16'h0004;
    localparam logic [15:0] VLAN_TWO_BYTES  = 16'h0008;

    // Live counter slots
    localparam int CNT_BCAST_CTRL = 0;
    localparam int CNT_UCAST_CTRL = 1;
    localparam int CNT_PAUSE      = 2;
    localparam int CNT_PAYLOAD    = 3;
    localparam int CNT_FRAME      = 4;
    localparam int NUM_CNT        = 5;

    typedef struct packed {
        logic        is_control;
        logic        is_pause;
        logic        is_broadcast;
        logic        is_unicast;
        logic        fcs_err;
        logic        undersize_err;
        logic        oversize_err;
        logic        length_err;
        logic        vlan_single;
        logic        vlan_stacked;
        logic [15:0] payload_bytes;
        logic [15:0] frame_bytes;
    } tx_frame_info_t;

endpackage : tx_stats_pkg

// [core/tx_statistics_counters.sv]
/*
 * Transmit statistics counter bank: 64-bit frame and byte counters with
 * snapshot freeze, parity checking and a global clear, read over APB.
 * Assumes frame events come from the transmit datapath on pclk, one
 * end-of-frame pulse per frame, and that the MAC control word is on pclk.
 */
// Our own choice: the APB slave port.
// Overview of operation
// - Every statistic is 64 bits, read as low then high word at adjacent offsets.
// - Count valid broadcast control frames; data frames excluded.
// - Count valid pause frames in a dedicated counter.
// - Count valid unicast control frames; data frames excluded.
// - Short-frame counter always reads zero in both halves.
// - Frames under nine bytes never sent; shorter frames padded to 64 bytes.
// - Config bit 2 freezes readable values at a snapshot; counting continues.
// - Status bit 1 reads one while the freeze is active.
// - Status bit 0 sets on any counter parity error.
// - Writing one to config bit 1 clears parity status; bit self-clears.
// - Writing one to config bit 0 resets all counters; bit self-clears.
// - Payload byte counter adds payload of error-free frames.
// - With VLAN detection off, add 4 or 8 tag bytes as payload.
// - Frame byte counter adds all bytes of error-free frames.
`timescale 1ns/1ps
module tx_statistics_counters
    import tx_stats_pkg::*;
#(
    parameter int ADDR_W = 14
) (
    // Clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Transmit datapath events
    input  wire logic              frame_end,
    input  wire tx_frame_info_t    frame_info,
    // Transmit MAC control word
    input  wire logic [31:0]       transmit_mac_control_word
);

    logic [63:0]          live_ff [NUM_CNT];
    logic [63:0]          nxt_live [NUM_CNT];
    logic [63:0]          snap_ff [NUM_CNT];
    logic [NUM_CNT-1:0]   parity_ff;
    logic [NUM_CNT-1:0]   parity_bad;
    logic [63:0]          incr [NUM_CNT];
    logic                 freeze_ff;
    logic                 perr_ff;
    logic [31:0]          prdata_ff;

    logic [11:0]          rd_idx;
    logic                 setup_ph;
    logic                 wr_access;
    logic                 cfg_wr;
    logic                 cnt_clear;
    logic                 perr_clear;
    logic                 frame_ok;
    logic                 sent;
    logic [15:0]          eff_frame;
    logic [15:0]          eff_payload;
    logic [15:0]          vlan_add;

    // Zero wait states: read data is registered in the setup cycle
    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign prdata  = prdata_ff;

    assign rd_idx    = 12'(paddr[ADDR_W-1:2]);
    assign setup_ph  = psel & ~penable;
    assign wr_access = psel & penable & pwrite;
    assign cfg_wr    = wr_access & pstrb[0] & (rd_idx == IDX_CONFIG);
    assign cnt_clear  = cfg_wr & pwdata[CFG_RESET_BIT];
    assign perr_clear = cfg_wr & pwdata[CFG_PCLR_BIT];

    // Frame qualification
    assign frame_ok = ~(frame_info.fcs_err | frame_info.undersize_err |
                        frame_info.oversize_err | frame_info.length_err);
    // Anything under the minimum is never put on the wire, so it is dropped here
    assign sent = frame_end & (frame_info.frame_bytes >= MIN_TX_BYTES);
    assign eff_frame = (frame_info.frame_bytes < PAD_TX_BYTES) ?
                       PAD_TX_BYTES : frame_info.frame_bytes;

    always_comb begin
        vlan_add = 16'h0000;
        if (transmit_mac_control_word[MAC_VLAN_OFF_BIT]) begin
            if (frame_info.vlan_stacked) begin
                vlan_add = VLAN_TWO_BYTES;
            end else if (frame_info.vlan_single) begin
                vlan_add = VLAN_ONE_BYTES;
            end
        end
    end
    assign eff_payload = frame_info.payload_bytes + vlan_add;

    // Per-counter increments, applied only on the end-of-frame pulse
    always_comb begin
        for (int k = 0; k < NUM_CNT; k++) begin
            incr[k] = 64'h0;
        end
        if (sent && frame_ok) begin
            if (frame_info.is_control && frame_info.is_broadcast) begin
                incr[CNT_BCAST_CTRL] = 64'h1;
            end
            if (frame_info.is_control && frame_info.is_unicast) begin
                incr[CNT_UCAST_CTRL] = 64'h1;
            end
            if (frame_info.is_pause) begin
                incr[CNT_PAUSE] = 64'h1;
            end
            incr[CNT_PAYLOAD] = {48'h0, eff_payload};
            incr[CNT_FRAME]   = {48'h0, eff_frame};
        end
    end

    // One live counter, its parity and its snapshot per slot
    genvar g;
    generate
        for (g = 0; g < NUM_CNT; g++) begin : g_cnt
            assign nxt_live[g]   = cnt_clear ? 64'h0 : live_ff[g] + incr[g];
            assign parity_bad[g] = (^live_ff[g]) != parity_ff[g];

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    live_ff[g]   <= 64'h0;
                    parity_ff[g] <= 1'b0;
                end else begin
                    live_ff[g]   <= nxt_live[g];
                    parity_ff[g] <= ^nxt_live[g];
                end
            end

            // Snapshot taken when the freeze goes from off to on
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    snap_ff[g] <= 64'h0;
                end else if (cnt_clear) begin
                    snap_ff[g] <= 64'h0;
                end else if (cfg_wr && pwdata[CFG_FREEZE_BIT] && !freeze_ff) begin
                    snap_ff[g] <= live_ff[g];
                end
            end
        end
    endgenerate

    // Only the freeze bit is stored; the other two act as write pulses
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            freeze_ff <= RST_FREEZE;
        end else if (cfg_wr) begin
            freeze_ff <= pwdata[CFG_FREEZE_BIT];
        end
    end

    // A new error in the clearing cycle wins over the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            perr_ff <= RST_PERR;
        end else if (|parity_bad) begin
            perr_ff <= 1'b1;
        end else if (perr_clear) begin
            perr_ff <= 1'b0;
        end
    end

    function automatic logic [31:0] view_word(input logic [63:0] live,
                                              input logic [63:0] snap,
                                              input logic        frozen,
                                              input logic        upper);
        logic [63:0] v;
        v = frozen ? snap : live;
        return upper ? v[63:32] : v[31:0];
    endfunction : view_word

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h0;
        end else if (setup_ph && !pwrite) begin
            case (rd_idx)
                IDX_BCAST_CTRL_LO, IDX_BCAST_CTRL_HI:
                    prdata_ff <= view_word(live_ff[CNT_BCAST_CTRL], snap_ff[CNT_BCAST_CTRL],
                                           freeze_ff, rd_idx[0]);
                IDX_UCAST_CTRL_LO, IDX_UCAST_CTRL_HI:
                    prdata_ff <= view_word(live_ff[CNT_UCAST_CTRL], snap_ff[CNT_UCAST_CTRL],
                                           freeze_ff, rd_idx[0]);
                IDX_PAUSE_LO, IDX_PAUSE_HI:
                    prdata_ff <= view_word(live_ff[CNT_PAUSE], snap_ff[CNT_PAUSE],
                                           freeze_ff, rd_idx[0]);
                IDX_SHORT_LO, IDX_SHORT_HI:
                    prdata_ff <= 32'h0;
                IDX_CONFIG:
                    prdata_ff <= {29'h0, freeze_ff, 2'b00};
                IDX_STATUS:
                    prdata_ff <= {30'h0, freeze_ff, perr_ff};
                IDX_PAYLOAD_LO, IDX_PAYLOAD_HI:
                    prdata_ff <= view_word(live_ff[CNT_PAYLOAD], snap_ff[CNT_PAYLOAD],
                                           freeze_ff, rd_idx[0]);
                IDX_FRAME_LO, IDX_FRAME_HI:
                    prdata_ff <= view_word(live_ff[CNT_FRAME], snap_ff[CNT_FRAME],
                                           freeze_ff, rd_idx[0]);
                default:
                    prdata_ff <= 32'h0;
            endcase
        end
    end

endmodule : tx_statistics_counters

// [verif/tx_stats_props.sv]
/* Port checker for the transmit statistics bank.
   Assumes the one-cycle APB access phase; bound to every bank instance. */
`timescale 1ns/1ps
module tx_stats_props
    import tx_stats_pkg::*;
#(
    parameter int ADDR_W = 14
) (
    // Clock and reset
    input wire logic              pclk,
    input wire logic              presetn,
    // APB
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [3:0]        pstrb,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    // Frame events and MAC word
    input wire logic              frame_end,
    input wire tx_frame_info_t    frame_info,
    input wire logic [31:0]       transmit_mac_control_word
);
    logic frz_ff;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Own copy of the freeze bit, so status is judged against writes, not the bank
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            frz_ff <= 1'b0;
        else if (psel && penable && pwrite && pstrb[0] && paddr[13:2] == IDX_CONFIG)
            frz_ff <= pwdata[CFG_FREEZE_BIT];
    end
    sequence rd_of(logic [11:0] idx);
        psel && !penable && !pwrite && paddr[13:2] == idx;
    endsequence
    a_short_lo_zero: assert property (rd_of(IDX_SHORT_LO) |=> prdata == 32'h0)
        else $error("short frame low word not zero");
    a_short_hi_zero: assert property (rd_of(IDX_SHORT_HI) |=> prdata == 32'h0)
        else $error("short frame high word not zero");
    a_reserved_reads_zero: assert property (psel && !penable && !pwrite &&
        paddr[13:2] inside {[12'h836:12'h844], [12'h847:12'h85f]} |=> prdata == 32'h0)
        else $error("reserved index read not zero");
    a_config_pulses_clear: assert property (
        rd_of(IDX_CONFIG) |=> prdata[1:0] == 2'h0)
        else $error("config pulse bits read back set");
    a_config_freeze_bit: assert property (
        rd_of(IDX_CONFIG) |=> prdata[31:2] == {29'h0, frz_ff})
        else $error("config freeze bit or reserved bits wrong");
    a_status_frozen: assert property (
        rd_of(IDX_STATUS) |=> prdata[STS_FROZEN_BIT] == frz_ff)
        else $error("status frozen bit differs from freeze");
    a_status_upper_zero: assert property (rd_of(IDX_STATUS) |=> prdata[31:2] == 30'h0)
        else $error("status reserved bits set");
    a_no_bus_error: assert property (pready && !pslverr)
        else $error("bus not ready or error flagged");
    a_read_data_holds: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
        else $error("read data moved without a read");
endmodule : tx_stats_props

bind tx_statistics_counters tx_stats_props #(.ADDR_W(ADDR_W)) u_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .frame_end(frame_end), .frame_info(frame_info),
    .transmit_mac_control_word(transmit_mac_control_word));

// [verif/tx_statistics_counters_tb.sv]
/* Self-checking bench for the transmit statistics bank.
   Assumes APB with pready from the bank and one end pulse per frame. */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tx_statistics_counters_tb
    import tx_stats_pkg::*;
;
    logic           pclk = 1'b0, presetn = 1'b0;
    logic           psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [13:0]    paddr = 14'h0;
    logic [31:0]    pwdata = 32'h0, prdata, rd, mac_word = 32'h0;
    logic [3:0]     pstrb = 4'hf;
    logic           pready, pslverr, frame_end = 1'b0;
    tx_frame_info_t frame_info = '0;
    logic [63:0]    exp_cnt [NUM_CNT], snap [NUM_CNT];
    logic [11:0]    lo_idx [NUM_CNT] = '{IDX_BCAST_CTRL_LO, IDX_UCAST_CTRL_LO,
                                         IDX_PAUSE_LO, IDX_PAYLOAD_LO, IDX_FRAME_LO};
    int             fail_count = 0, num_checks = 0, cyc = 0;

    always #2.5 pclk = ~pclk;

    tx_statistics_counters #(.ADDR_W(14)) u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .frame_end(frame_end),
        .frame_info(frame_info), .transmit_mac_control_word(mac_word));

    task automatic report_and_stop();
        if (fail_count == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : report_and_stop

    task automatic apb(input logic wr, input logic [11:0] idx, input logic [31:0] wd,
                       input logic [3:0] stb, output logic [31:0] rdv);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'h0};
        pwdata <= wd;
        pstrb <= stb;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdv = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd_chk(input logic [11:0] idx, input logic [31:0] e);
        logic [31:0] v;
        apb(1'b0, idx, 32'h0, 4'hf, v);
        `CHK($sformatf("reg %h", idx), e, v)
    endtask : rd_chk

    task automatic check_all(input logic [63:0] e [NUM_CNT]);
        for (int i = 0; i < NUM_CNT; i++) begin
            rd_chk(lo_idx[i], e[i][31:0]);
            rd_chk(lo_idx[i] + 12'h1, e[i][63:32]);
        end
    endtask : check_all

    // Expected counts follow the frame rules, not the bank's own logic
    task automatic send(input tx_frame_info_t f);
        logic ok;
        // Expectation is formed at the driving edge, so a MAC word just changed is seen
        @(posedge pclk);
        ok = f.frame_bytes >= MIN_TX_BYTES &&
             !(f.fcs_err | f.undersize_err | f.oversize_err | f.length_err);
        if (ok) begin
            exp_cnt[CNT_BCAST_CTRL] += 64'(f.is_control & f.is_broadcast);
            exp_cnt[CNT_UCAST_CTRL] += 64'(f.is_control & f.is_unicast);
            exp_cnt[CNT_PAUSE] += 64'(f.is_pause);
            exp_cnt[CNT_PAYLOAD] += 64'(f.payload_bytes) + (!mac_word[MAC_VLAN_OFF_BIT] ?
                64'h0 : f.vlan_stacked ? 64'h8 : f.vlan_single ? 64'h4 : 64'h0);
            exp_cnt[CNT_FRAME] += 64'(f.frame_bytes < PAD_TX_BYTES ? PAD_TX_BYTES : f.frame_bytes);
        end
        frame_end <= 1'b1;
        frame_info <= f;
        @(posedge pclk);
        frame_end <= 1'b0;
    endtask : send

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            fail_count++;
            report_and_stop();
        end
    end

    initial begin
        foreach (exp_cnt[i]) exp_cnt[i] = 64'h0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        check_all(exp_cnt);
        rd_chk(IDX_STATUS, 32'h0);
        send({10'h280, 16'h0050, 16'h0064});
        send({10'h340, 16'h002e, 16'h0040});
        send({10'h240, 16'h0005, 16'h0009});
        send({10'h2a0, 16'h0050, 16'h0064});
        send({10'h250, 16'h0050, 16'h0064});
        send({10'h248, 16'h0050, 16'h0064});
        send({10'h244, 16'h0050, 16'h0064});
        send({10'h280, 16'h0002, 16'h0008});
        send({10'h080, 16'h0064, 16'h0078});
        send({10'h002, 16'h000a, 16'h0040});
        mac_word <= 32'h2;
        send({10'h002, 16'h000a, 16'h0040});
        send({10'h003, 16'h000a, 16'h0040});
        check_all(exp_cnt);
        rd_chk(IDX_SHORT_LO, 32'h0);
        rd_chk(IDX_SHORT_HI, 32'h0);
        snap = exp_cnt;
        apb(1'b1, IDX_CONFIG, 32'h4, 4'hf, rd);
        send({10'h280, 16'h0050, 16'h0064});
        check_all(snap);
        rd_chk(IDX_STATUS, 32'h2);
        rd_chk(IDX_CONFIG, 32'h4);
        apb(1'b1, IDX_CONFIG, 32'h0, 4'hf, rd);
        check_all(exp_cnt);
        rd_chk(IDX_STATUS, 32'h0);
        apb(1'b1, IDX_CONFIG, 32'h2, 4'hf, rd);
        rd_chk(IDX_STATUS, 32'h0);
        rd_chk(IDX_CONFIG, 32'h0);
        apb(1'b1, IDX_CONFIG, 32'h4, 4'he, rd);
        rd_chk(IDX_STATUS, 32'h0);
        apb(1'b1, IDX_PAUSE_LO, 32'hffffffff, 4'hf, rd);
        apb(1'b1, 12'h840, 32'hffffffff, 4'hf, rd);
        rd_chk(12'h840, 32'h0);
        rd_chk(12'h850, 32'h0);
        rd_chk(IDX_PAUSE_LO, exp_cnt[CNT_PAUSE][31:0]);
        apb(1'b1, IDX_CONFIG, 32'h1, 4'hf, rd);
        foreach (exp_cnt[i]) exp_cnt[i] = 64'h0;
        check_all(exp_cnt);
        rd_chk(IDX_CONFIG, 32'h0);
        report_and_stop();
    end
endmodule : tx_statistics_counters_tb
